// [ascs_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ascs_defines.svh"

module ascs_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             tx_serial_out,
	input  wire logic        rx_char_valid,
	input  wire logic [8:0]  rx_char,
	input  wire logic        rx_full_flag,
	input  wire logic        rx_line_quiet_flag,
	input  wire logic        rx_overrun_flag,
	input  wire logic        noise_flag,
	input  wire logic        framing_fault_flag,
	input  wire logic        parity_fault_flag,
	input  wire logic        rx_line_quiet_evt,
	input  wire logic        rx_addr_mark_evt,
	output logic             rx_on,
	output logic             rx_standby,
	output logic             status_read_pulse,
	output logic             data_read_pulse,
	output logic             tx_irq,
	output logic             rx_irq,
	output logic             err_irq
);
	import ascs_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0]  line_config_r;
	logic [7:0]  tx_rx_control_r;
	logic        tx_ninth_bit_r;
	logic        rx_dma_req_en_r;
	logic        tx_dma_req_en_r;
	logic [3:0]  err_en_r;
	logic        rx_ninth_bit_r;
	logic [7:0]  rx_data_r;
	logic [7:0]  tx_buf_r;
	logic        tx_buf_full_r;
	logic        tx_empty_flag_r;
	logic        tx_done_flag_r;
	logic        empty_armed_r;
	logic        te_prev_r;
	logic        preamble_pend_r;
	logic        after_break_r;
	logic        start_r;
	logic [10:0] frame_r;
	logic [3:0]  frame_len_r;
	logic        sh_busy;

	logic module_enable;
	logic nine_bit;
	logic wake_addr;
	logic tx_enable_bit;
	logic break_send_bit;
	logic rx_standby_bit;
	logic tx_active;
	logic tx_idle;
	logic wr_done;
	logic rd_done;
	logic hit;
	logic [7:0] rd_byte;
	logic [7:0] status_one;
	logic take_break;
	logic take_mark;
	logic take_preamble;
	logic take_data;

	assign module_enable  = line_config_r[`ASCS_CFG_MODULE_ENABLE];
	assign nine_bit       = line_config_r[`ASCS_CFG_NINE_BIT];
	assign wake_addr      = line_config_r[`ASCS_CFG_WAKE_ADDR];
	assign tx_enable_bit  = tx_rx_control_r[`ASCS_C2_TX_ENABLE];
	assign break_send_bit = tx_rx_control_r[`ASCS_C2_BREAK_SEND];
	assign rx_standby_bit = tx_rx_control_r[`ASCS_C2_RX_STANDBY];

	// ----------------------------------------------------------------
	// Frame builder
	// ----------------------------------------------------------------
	// Returns {length, bits}; bits leave LSB first
	function automatic logic [14:0] ascs_frame(
		input ascs_frame_type kind,
		input logic           nine,
		input logic [7:0]     data,
		input logic           t8
	);
		logic [3:0] len;
		len = nine ? 4'd11 : 4'd10;
		unique case (kind)
			ASCS_FR_DATA:  ascs_frame = nine ? {len, 1'b1, t8, data, 1'b0}
			                                 : {len, 1'b1, 1'b1, data, 1'b0};
			ASCS_FR_IDLE:  ascs_frame = {len, 11'h7ff};
			ASCS_FR_BREAK: ascs_frame = {len, 11'h000};
			ASCS_FR_MARK:  ascs_frame = {4'd1, 11'h7ff};
		endcase
	endfunction

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// One wait state keeps pready and prdata straight from flip-flops
	assign wr_done = psel & penable & pready & pwrite;
	assign rd_done = psel & penable & pready & ~pwrite;

	assign status_one = {tx_empty_flag_r, tx_done_flag_r, rx_full_flag, rx_line_quiet_flag,
	                     rx_overrun_flag, noise_flag, framing_fault_flag, parity_fault_flag};

	always_comb begin
		hit     = 1'b1;
		rd_byte = 8'h00;
		unique case (paddr)
			`ASCS_OFF_LINE_CONFIG:     rd_byte = line_config_r;
			`ASCS_OFF_TX_RX_CONTROL:   rd_byte = tx_rx_control_r;
			`ASCS_OFF_NINTH_ERR_EN:    rd_byte = {rx_ninth_bit_r, tx_ninth_bit_r,
			                                      rx_dma_req_en_r, tx_dma_req_en_r, err_en_r};
			`ASCS_OFF_LINE_STATUS_ONE: rd_byte = status_one;
			`ASCS_OFF_DATA_BUFFER:     rd_byte = rx_data_r;
			default:                   hit     = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~hit;
			if (psel & penable & ~pready & ~pwrite) begin
				prdata <= {24'h00_0000, rd_byte};
			end
		end
	end

	// Side-effect strobes for the receiver's own flag-clearing sequences
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_read_pulse <= 1'b0;
			data_read_pulse   <= 1'b0;
		end else begin
			status_read_pulse <= rd_done & (paddr == `ASCS_OFF_LINE_STATUS_ONE);
			data_read_pulse   <= rd_done & (paddr == `ASCS_OFF_DATA_BUFFER);
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_config_r <= `ASCS_RST_LINE_CONFIG;
		end else if (wr_done && paddr == `ASCS_OFF_LINE_CONFIG) begin
			line_config_r <= {5'h00, pwdata[2:0]};
		end
	end

	// Software write wins over a wake event landing in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_rx_control_r <= `ASCS_RST_TX_RX_CONTROL;
		end else if (wr_done && paddr == `ASCS_OFF_TX_RX_CONTROL) begin
			tx_rx_control_r <= pwdata[7:0];
		end else if (rx_standby_bit && (wake_addr ? rx_addr_mark_evt : rx_line_quiet_evt)) begin
			tx_rx_control_r[`ASCS_C2_RX_STANDBY] <= 1'b0;
		end
	end

	// DMA enables are storage only; nothing here acts on them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_dma_req_en_r <= 1'b0;
			tx_dma_req_en_r <= 1'b0;
			err_en_r        <= `ASCS_RST_ERR_EN;
		end else if (wr_done && paddr == `ASCS_OFF_NINTH_ERR_EN) begin
			rx_dma_req_en_r <= pwdata[5];
			tx_dma_req_en_r <= pwdata[4];
			err_en_r        <= pwdata[3:0];
		end
	end

	// ----------------------------------------------------------------
	// Unreset data storage
	// ----------------------------------------------------------------
	// Reset leaves these untouched, so they sit outside the reset network
	always_ff @(posedge pclk) begin
		if (wr_done && paddr == `ASCS_OFF_NINTH_ERR_EN) begin
			tx_ninth_bit_r <= pwdata[`ASCS_C3_TX_NINTH];
		end
	end

	always_ff @(posedge pclk) begin
		if (rx_char_valid) begin
			rx_data_r      <= rx_char[7:0];
			rx_ninth_bit_r <= nine_bit ? rx_char[8] : rx_char[7];
		end
	end

	always_ff @(posedge pclk) begin
		if (wr_done && paddr == `ASCS_OFF_DATA_BUFFER) begin
			tx_buf_r <= pwdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Transmit sequencing
	// ----------------------------------------------------------------
	assign tx_active = module_enable & tx_enable_bit;
	assign tx_idle   = ~sh_busy & ~start_r;

	// Break outranks the preamble, so an early break toggle replaces it
	always_comb begin
		take_break    = 1'b0;
		take_mark     = 1'b0;
		take_preamble = 1'b0;
		take_data     = 1'b0;
		if (tx_active && tx_idle) begin
			if (break_send_bit) begin
				take_break = 1'b1;
			end else if (after_break_r) begin
				take_mark = 1'b1;
			end else if (preamble_pend_r || !te_prev_r) begin
				take_preamble = 1'b1;
			end else if (tx_buf_full_r) begin
				take_data = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			te_prev_r <= 1'b0;
		end else begin
			te_prev_r <= tx_active;
		end
	end

	// A fresh enable edge queues one idle character, even mid-frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			preamble_pend_r <= 1'b0;
		end else if (take_preamble || take_break || !module_enable) begin
			preamble_pend_r <= 1'b0;
		end else if (tx_active && !te_prev_r) begin
			preamble_pend_r <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			after_break_r <= 1'b0;
		end else if (take_break) begin
			after_break_r <= 1'b1;
		end else if (take_mark || !tx_active) begin
			after_break_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_buf_full_r <= 1'b0;
		end else if (wr_done && paddr == `ASCS_OFF_DATA_BUFFER) begin
			tx_buf_full_r <= 1'b1;
		end else if (take_data || !module_enable) begin
			tx_buf_full_r <= 1'b0;
		end
	end

	// With the transmit enable low nothing new starts; the shifter ends its frame and idles high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_r     <= 1'b0;
			frame_r     <= 11'h7ff;
			frame_len_r <= 4'h0;
		end else begin
			start_r <= take_break | take_mark | take_preamble | take_data;
			if (take_break) begin
				{frame_len_r, frame_r} <= ascs_frame(ASCS_FR_BREAK, nine_bit, tx_buf_r,
				                                     tx_ninth_bit_r);
			end else if (take_mark) begin
				{frame_len_r, frame_r} <= ascs_frame(ASCS_FR_MARK, nine_bit, tx_buf_r,
				                                     tx_ninth_bit_r);
			end else if (take_preamble) begin
				{frame_len_r, frame_r} <= ascs_frame(ASCS_FR_IDLE, nine_bit, tx_buf_r,
				                                     tx_ninth_bit_r);
			end else if (take_data) begin
				{frame_len_r, frame_r} <= ascs_frame(ASCS_FR_DATA, nine_bit, tx_buf_r,
				                                     tx_ninth_bit_r);
			end
		end
	end

	ascs_tx_shift u_shift (
		.pclk       (pclk),
		.presetn    (presetn),
		.enable     (module_enable),
		.start      (start_r),
		.frame      (frame_r),
		.frame_len  (frame_len_r),
		.busy       (sh_busy),
		.serial_out (tx_serial_out)
	);

	// ----------------------------------------------------------------
	// Transmit status flags
	// ----------------------------------------------------------------
	// A status read with the flag high arms the clear; the next data write uses it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			empty_armed_r <= 1'b0;
		end else if (wr_done && paddr == `ASCS_OFF_DATA_BUFFER) begin
			empty_armed_r <= 1'b0;
		end else if (rd_done && paddr == `ASCS_OFF_LINE_STATUS_ONE && tx_empty_flag_r) begin
			empty_armed_r <= 1'b1;
		end
	end

	// Transfer sets win over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_empty_flag_r <= 1'b1;
		end else if (take_data || !module_enable) begin
			tx_empty_flag_r <= 1'b1;
		end else if (wr_done && paddr == `ASCS_OFF_DATA_BUFFER && empty_armed_r) begin
			tx_empty_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_done_flag_r <= 1'b1;
		end else begin
			tx_done_flag_r <= ~module_enable | (tx_empty_flag_r & tx_idle & ~tx_buf_full_r
			                  & ~preamble_pend_r & ~after_break_r
			                  & ~(tx_active & break_send_bit));
		end
	end

	// ----------------------------------------------------------------
	// Request and receiver control outputs
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_irq     <= 1'b0;
			rx_irq     <= 1'b0;
			err_irq    <= 1'b0;
			rx_on      <= 1'b0;
			rx_standby <= 1'b0;
		end else begin
			tx_irq <= module_enable
			          & ((tx_empty_flag_r & tx_rx_control_r[`ASCS_C2_TX_EMPTY_IE])
			          | (tx_done_flag_r & tx_rx_control_r[`ASCS_C2_TX_DONE_IE]));
			rx_irq <= ~rx_standby_bit
			          & ((rx_full_flag & tx_rx_control_r[`ASCS_C2_RX_FULL_IE])
			          | (rx_line_quiet_flag & tx_rx_control_r[`ASCS_C2_LINE_QUIET_IE]));
			err_irq <= |({rx_overrun_flag, noise_flag, framing_fault_flag, parity_fault_flag}
			             & err_en_r);
			rx_on      <= module_enable & tx_rx_control_r[`ASCS_C2_RX_ENABLE];
			rx_standby <= rx_standby_bit;
		end
	end

endmodule // ascs_top

`default_nettype wire

// [ascs_defines.svh]
`ifndef ASCS_DEFINES_SVH
`define ASCS_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ASCS_OFF_LINE_CONFIG      8'h00
`define ASCS_OFF_TX_RX_CONTROL    8'h04
`define ASCS_OFF_NINTH_ERR_EN     8'h08
`define ASCS_OFF_LINE_STATUS_ONE  8'h0c
`define ASCS_OFF_DATA_BUFFER      8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ASCS_CFG_MODULE_ENABLE    0
`define ASCS_CFG_NINE_BIT         1
`define ASCS_CFG_WAKE_ADDR        2

`define ASCS_C2_TX_EMPTY_IE       7
`define ASCS_C2_TX_DONE_IE        6
`define ASCS_C2_RX_FULL_IE        5
`define ASCS_C2_LINE_QUIET_IE     4
`define ASCS_C2_TX_ENABLE         3
`define ASCS_C2_RX_ENABLE         2
`define ASCS_C2_RX_STANDBY        1
`define ASCS_C2_BREAK_SEND        0

`define ASCS_C3_RX_NINTH          7
`define ASCS_C3_TX_NINTH          6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ASCS_RST_LINE_CONFIG      8'h00
`define ASCS_RST_TX_RX_CONTROL    8'h00
`define ASCS_RST_ERR_EN           4'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ASCS_BIT_CYCLES           16'd868

`endif

// [ascs_pkg.sv]
package ascs_pkg;

	typedef enum logic [1:0] {
		ASCS_FR_DATA  = 2'b00,
		ASCS_FR_IDLE  = 2'b01,
		ASCS_FR_BREAK = 2'b10,
		ASCS_FR_MARK  = 2'b11
	} ascs_frame_type;

	typedef enum logic {
		ASCS_SH_IDLE  = 1'b0,
		ASCS_SH_SHIFT = 1'b1
	} ascs_shift_state_type;

endpackage : ascs_pkg

// [ascs_tx_shift.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ascs_defines.svh"

module ascs_tx_shift (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        enable,
	input  wire logic        start,
	input  wire logic [10:0] frame,
	input  wire logic [3:0]  frame_len,
	output logic             busy,
	output logic             serial_out
);
	import ascs_pkg::*;

	ascs_shift_state_type state_r;
	logic [15:0]          bit_cnt_r;
	logic [3:0]           bits_left_r;
	logic [10:0]          shreg_r;
	logic [1:0]           hold_r;

	assign busy = (state_r == ASCS_SH_SHIFT);

	// Disabling the module drops any frame at once and parks the line high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r     <= ASCS_SH_IDLE;
			bit_cnt_r   <= 16'h0000;
			bits_left_r <= 4'h0;
			shreg_r     <= 11'h7ff;
			hold_r      <= 2'h0;
			serial_out  <= 1'b1;
		end else if (!enable) begin
			state_r    <= ASCS_SH_IDLE;
			hold_r     <= 2'h0;
			serial_out <= 1'b1;
		end else begin
			unique case (state_r)
				ASCS_SH_IDLE: begin
					if (hold_r != 2'h0) begin
						hold_r <= hold_r - 2'h1;
					end else begin
						serial_out <= 1'b1;
					end
					if (start) begin
						state_r     <= ASCS_SH_SHIFT;
						serial_out  <= frame[0];
						shreg_r     <= {1'b1, frame[10:1]};
						bits_left_r <= frame_len - 4'h1;
						bit_cnt_r   <= `ASCS_BIT_CYCLES - 16'h0001;
					end
				end
				ASCS_SH_SHIFT: begin
					if (bit_cnt_r != 16'h0000) begin
						bit_cnt_r <= bit_cnt_r - 16'h0001;
					end else if (bits_left_r == 4'h0) begin
						// Last level stands while the sequencer restarts: no glitch between breaks
						state_r <= ASCS_SH_IDLE;
						hold_r  <= 2'h2;
					end else begin
						serial_out  <= shreg_r[0];
						shreg_r     <= {1'b1, shreg_r[10:1]};
						bits_left_r <= bits_left_r - 4'h1;
						bit_cnt_r   <= `ASCS_BIT_CYCLES - 16'h0001;
					end
				end
			endcase
		end
	end

endmodule // ascs_tx_shift

`default_nettype wire

// [ascs_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ascs_defines.svh"
module ascs_monitor (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pwrite,
	input wire logic [7:0] paddr,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic       tx_serial_out,
	input wire logic       rx_full_flag,
	input wire logic       rx_line_quiet_flag,
	input wire logic       rx_overrun_flag,
	input wire logic       noise_flag,
	input wire logic       framing_fault_flag,
	input wire logic       parity_fault_flag,
	input wire logic       rx_standby,
	input wire logic       status_read_pulse,
	input wire logic       data_read_pulse,
	input wire logic       rx_irq,
	input wire logic       err_irq
);
	localparam logic [15:0] BIT_LEN = `ASCS_BIT_CYCLES;
	logic        last_r;
	logic [15:0] run_r;
	logic        rx_src;
	logic        err_src;
	assign rx_src = rx_full_flag | rx_line_quiet_flag;
	assign err_src = rx_overrun_flag | noise_flag | framing_fault_flag | parity_fault_flag;
	// ----------------------------------------------------------------
	// Line run length
	// ----------------------------------------------------------------
	// Saturates so that long idle stretches never wrap into a short run
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_r <= 1'b1;
			run_r  <= 16'hffff;
		end else begin
			last_r <= tx_serial_out;
			if (tx_serial_out != last_r)
				run_r <= 16'd1;
			else if (run_r != 16'hffff)
				run_r <= run_r + 16'd1;
		end
	end
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	sequence s_rd_done(logic [7:0] a);
		psel && penable && pready && !pwrite && paddr == a;
	endsequence
	sequence s_rx_quiet;
		!rx_src ##1 !rx_src;
	endsequence
	sequence s_err_quiet;
		!err_src ##1 !err_src;
	endsequence
	AST_PREADY_WAIT: assert property (s_wait |=> pready)
		else $error("pready late after access phase");
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_SLVERR_READY: assert property (pslverr |-> pready && psel && penable)
		else $error("pslverr outside a completing transfer");
	AST_STATUS_PULSE: assert property (s_rd_done(8'h0c) |=> status_read_pulse)
		else $error("status read pulse missing");
	AST_DATA_PULSE: assert property (s_rd_done(8'h10) |=> data_read_pulse)
		else $error("data read pulse missing");
	AST_STANDBY_MUTE: assert property (rx_standby && $past(rx_standby) |-> !rx_irq)
		else $error("receive request during standby");
	AST_RX_IRQ_SRC: assert property (s_rx_quiet |-> !rx_irq)
		else $error("receive request without a source");
	AST_ERR_IRQ_SRC: assert property (s_err_quiet |-> !err_irq)
		else $error("error request without a source");
	AST_BIT_TIME: assert property (tx_serial_out != last_r |-> run_r >= BIT_LEN)
		else $error("serial level held shorter than one bit");
endmodule // ascs_monitor
bind ascs_top ascs_monitor u_mon (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
	.tx_serial_out, .rx_full_flag, .rx_line_quiet_flag, .rx_overrun_flag,
	.noise_flag, .framing_fault_flag, .parity_fault_flag, .rx_standby,
	.status_read_pulse, .data_read_pulse, .rx_irq, .err_irq
);
`default_nettype wire

// [ascs_remote.sv]
`timescale 1ns/100ps
`default_nettype none
module ascs_remote (
	input wire logic   pclk,
	input wire logic   line,
	input wire logic   nine,
	output logic [10:0] frame_bits,
	output int          frame_count
);
	// Samples mid-bit and counts at mid stop bit, so a frame right behind is caught
	initial begin
		frame_count = 0;
		frame_bits = 11'h000;
		forever begin
			wait (line === 1'b1);
			@(posedge pclk iff line === 1'b0);
			repeat (434) @(posedge pclk);
			for (int i = 0; i < (nine ? 11 : 10); i++) begin
				if (i > 0)
					repeat (868) @(posedge pclk);
				frame_bits[i] = line;
			end
			frame_count++;
		end
	end
endmodule // ascs_remote
`default_nettype wire

// [async_serial_ctrl_status_test.sv]
`timescale 1ns/100ps
`default_nettype none
module async_serial_ctrl_status_test;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, t8;
	logic [7:0]  paddr, td;
	logic [31:0] pwdata, prdata, rdat, r;
	logic        tx_serial_out, tx_irq, rx_irq, err_irq, rx_on, rx_standby;
	logic        rx_char_valid, rx_full_flag, rx_line_quiet_flag, rx_overrun_flag;
	logic        noise_flag, framing_fault_flag, parity_fault_flag;
	logic        rx_line_quiet_evt, rx_addr_mark_evt, status_read_pulse, data_read_pulse;
	logic [8:0]  rx_char;
	logic [10:0] fbits;
	int          fcnt, miscompares, checks_done, seed, n;

	ascs_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .tx_serial_out, .rx_char_valid, .rx_char, .rx_full_flag,
		.rx_line_quiet_flag, .rx_overrun_flag, .noise_flag, .framing_fault_flag,
		.parity_fault_flag, .rx_line_quiet_evt, .rx_addr_mark_evt, .rx_on, .rx_standby,
		.status_read_pulse, .data_read_pulse, .tx_irq, .rx_irq, .err_irq);
	ascs_remote u_remote (.pclk, .line(tx_serial_out), .nine(1'b1), .frame_bits(fbits),
		.frame_count(fcnt));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	function automatic logic err_exp(input logic [3:0] en, input logic [3:0] fl);
		return |(en & fl);
	endfunction
	function automatic logic ninth_exp(input logic nine, input logic [8:0] ch);
		return nine ? ch[8] : ch[7];
	endfunction
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic pulse_evt(input logic q, input logic m);
		rx_line_quiet_evt <= q;
		rx_addr_mark_evt <= m;
		@(posedge pclk);
		rx_line_quiet_evt <= 1'b0;
		rx_addr_mark_evt <= 1'b0;
		tick(3);
	endtask
	task automatic wait_frames(input int k);
		n = 0;
		while (fcnt < k && n < 20000) begin
			@(posedge pclk);
			n++;
		end
		chk("frame_wait", 32'h1, fcnt >= k);
	endtask
	task automatic print_verdict;
		if (miscompares == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#600000;
		miscompares++;
		print_verdict();
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 30;
		{presetn, psel, penable, pwrite, paddr, pwdata, rx_char_valid, rx_char} = '0;
		{rx_full_flag, rx_line_quiet_flag, rx_overrun_flag, noise_flag} = '0;
		{framing_fault_flag, parity_fault_flag, rx_line_quiet_evt, rx_addr_mark_evt} = '0;
		tick(4);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(8'h04);
		chk("ctrl_reset", 32'h0, rdat);
		rd(8'h08);
		chk("err_en_reset", 32'h0, rdat & 32'h3f);
		rd(8'h0c);
		chk("status_reset", 32'hc0, rdat);
		rd(8'h14);
		chk("unmapped", 32'h1, {rdat[30:0], rerr});
		wr(8'h04, 32'hc0);
		tick(2);
		chk("tx_irq_disabled", 32'h0, tx_irq);
		wr(8'h00, 32'h01);
		for (int i = 0; i < 3; i++) begin
			wr(8'h04, 32'h80 >> i);
			tick(2);
			chk("tx_irq", i < 2, tx_irq);
		end
		wr(8'h04, 32'h34);
		tick(2);
		chk("rx_on", 32'h1, rx_on);
		for (int i = 0; i < 8; i++) begin
			r = $random(seed);
			rx_full_flag <= r[0];
			rx_line_quiet_flag <= r[1];
			tick(3);
			chk("rx_irq", r[0] | r[1], rx_irq);
		end
		{rx_full_flag, rx_line_quiet_flag} <= 2'b10;
		for (int w = 0; w < 2; w++) begin
			wr(8'h00, 32'h01 | (w << 2));
			wr(8'h04, 32'h36);
			tick(2);
			chk("standby_mute", 32'h0, rx_irq);
			pulse_evt(w == 0 ? 1'b0 : 1'b1, w == 0 ? 1'b1 : 1'b0);
			chk("standby_kept", 32'h1, rx_standby);
			pulse_evt(w == 0 ? 1'b1 : 1'b0, w == 0 ? 1'b0 : 1'b1);
			chk("standby_woken", 32'h0, rx_standby);
			chk("rx_irq_back", 32'h1, rx_irq);
		end
		wr(8'h04, 32'h30);
		rd(8'h0c);
		chk("rx_off", 32'h0, rx_on);
		chk("flags_kept", 32'he0, rdat);
		rx_full_flag <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			wr(8'h08, 32'h1 << i);
			for (int j = 0; j < 4; j++) begin
				r = $random(seed);
				{rx_overrun_flag, noise_flag, framing_fault_flag, parity_fault_flag} <= r[3:0];
				tick(3);
				chk("err_irq", err_exp(4'h1 << i, r[3:0]), err_irq);
			end
		end
		{rx_overrun_flag, noise_flag, framing_fault_flag, parity_fault_flag} <= 4'h0;
		for (int m = 0; m < 2; m++) begin
			wr(8'h00, 32'h01 | (m << 1));
			r = $random(seed);
			rx_char <= r[8:0];
			rx_char_valid <= 1'b1;
			@(posedge pclk);
			rx_char_valid <= 1'b0;
			rd(8'h08);
			chk("rx_ninth", ninth_exp(m[0], r[8:0]), rdat[7]);
			rd(8'h10);
			chk("rx_data", r[7:0], rdat);
		end
		r = $random(seed);
		td = r[7:0];
		t8 = r[8];
		wr(8'h08, {25'h0, t8, 6'h0});
		rd(8'h0c);
		wr(8'h10, td);
		rd(8'h0c);
		chk("empty_cleared", 32'h0, rdat[7]);
		wr(8'h04, 32'h08);
		n = 0;
		while (tx_serial_out !== 1'b0 && n < 12000) begin
			@(posedge pclk);
			n++;
		end
		chk("preamble_len", 32'h1, n >= 8670 && n <= 9560);
		rd(8'h0c);
		chk("empty_done_busy", 32'h2, rdat[7:6]);
		wait_frames(1);
		chk("tx_frame", {1'b1, t8, td, 1'b0}, fbits);
		tick(2000);
		rd(8'h0c);
		chk("done_after", 32'h1, rdat[6]);
		wr(8'h04, 32'h09);
		wait_frames(2);
		chk("break_frame", 32'h0, fbits);
		n = 0;
		while (tx_serial_out === 1'b0 && n < 1200) begin
			@(posedge pclk);
			n++;
		end
		chk("break_run", 32'h1, n >= 1200);
		wr(8'h04, 32'h08);
		n = 0;
		while (tx_serial_out !== 1'b1 && n < 12000) begin
			@(posedge pclk);
			n++;
		end
		chk("break_end", 32'h1, n >= 7000 && n < 12000);
		tick(2000);
		chk("line_idle", 32'h1, tx_serial_out);
		wr(8'h04, 32'h00);
		rd(8'h0c);
		wr(8'h10, td);
		wr(8'h00, 32'h02);
		rd(8'h0c);
		chk("module_off_flags", 32'h3, rdat[7:6]);
		print_verdict();
	end
endmodule // async_serial_ctrl_status_test
`default_nettype wire
